// *** bcr_consts.vh ***
`ifndef BCR_CONSTS_VH
`define BCR_CONSTS_VH
// register indices; byte address on apb is four times the low byte
`define BCR_IDX_CTRL0     32'h50000082
`define BCR_IDX_CTRL1     32'h50000084
`define BCR_IDX_CTRL2     32'h50000086
`define BCR_IDX_RA0       32'h50000088
`define BCR_IDX_RA1       32'h5000008A
`define BCR_IDX_RB0       32'h5000008C
`define BCR_IDX_RB1       32'h5000008E
`define BCR_IDX_CORE0     32'h50000090
`define BCR_IDX_CORE1     32'h50000092
`define BCR_IDX_PA0       32'h50000094
`define BCR_IDX_PA1       32'h50000096
`define BCR_IDX_RET0      32'h50000098
`define BCR_IDX_RET1      32'h5000009A
`define BCR_IDX_TRIM      32'h5000009C
`define BCR_IDX_TEST0     32'h5000009E
`define BCR_IDX_TEST1     32'h500000A0
`define BCR_IDX_STAT0     32'h500000A2
`define BCR_IDX_STAT1     32'h500000A4
`define BCR_IDX_STAT2     32'h500000A6
`define BCR_IDX_STAT3     32'h500000A8
`define BCR_IDX_STAT4     32'h500000AA
`define BCR_IDX_TRIMA     32'h500000AC
`define BCR_IDX_TRIMB     32'h500000AE
`define BCR_IDX_TRIMC     32'h500000B0
`define BCR_IDX_TRIMP     32'h500000B2
`define BCR_IDX_IRQ_FLAGS 32'h500000B4
`define BCR_IDX_IRQ_CLEAR 32'h500000B6
`define BCR_IDX_IRQ_MASK  32'h500000B8
// low bytes of the first and last index, which is all the decoder compares
`define BCR_LO_FIRST      8'h82
`define BCR_LO_LAST       8'hB8
// slots in the storage array, index minus first index, halved
`define BCR_SLOT_CTRL0    5'h00
`define BCR_SLOT_CTRL1    5'h01
`define BCR_SLOT_CTRL2    5'h02
`define BCR_SLOT_RA0      5'h03
`define BCR_SLOT_RA1      5'h04
`define BCR_SLOT_STAT0    5'h10
`define BCR_SLOT_STAT4    5'h14
`define BCR_SLOT_FLAGS    5'h19
`define BCR_SLOT_CLEAR    5'h1A
`define BCR_SLOT_MASK     5'h1B
// reset values
`define BCR_RST_CTRL0     16'h2F24
`define BCR_RST_CTRL1     16'h5410
`define BCR_RST_CTRL2     16'h882D
`define BCR_RST_RA0       16'hA1A4
`define BCR_RST_RA1       16'hD890
`define BCR_RST_LIM       5'h04
// field positions
`define BCR_F_MODE        1:0
`define BCR_F_PRIO        10:3
`define BCR_F_LVSW        13
`define BCR_F_FAST        14
`define BCR_F_DELAY       15:11
`define BCR_F_GIDLE       10:5
`define BCR_F_TOLIM       4:0
`define BCR_F_TRIG        15:12
`define BCR_F_RES         11:8
`define BCR_F_QRAMP       15
`define BCR_F_CEIL_HV     9:5
`define BCR_F_FLOOR       4:0
`define BCR_F_CEIL_LV     13:10
`define BCR_F_HYST        9:5
`define BCR_F_IDLE_MIN    4:0
// timing
`define BCR_CLK_NS        40
`define BCR_US_NS         1000
`define BCR_CYC_PER_US    ((`BCR_US_NS + `BCR_CLK_NS - 1) / `BCR_CLK_NS)
`define BCR_IDLE_STEP_NS  125
`define BCR_TO_STEP_HNS   125
`define BCR_CLK_HNS       (2 * `BCR_CLK_NS)
`endif

// *** bcr_buck_ctrl.v ***
// Summary of operation
// - run-mode 01 runs active, 10 runs sleep, 00 and 11 keep converter off
// - rails charged in order of four two-bit ids, lowest pair first
// - fast-launch bit forces current limit to maximum during start-up wait
// - low-battery switch selects low-voltage settings while battery is low
// - bias comes on, then converter runs after 0 to 31 us wait
// - idle reaching global ceiling ramps the limit down faster than normal
// - switch closed beyond limit flags timeout and forces state machine onward
// - timeout events counted; interrupt raised when count reaches trigger number
// - programmed run of clean charge events clears the timeout counter
// - quick-ramp bit doubles the ramp step of rail_a
// - rail_a high-battery ceiling code N means 30 mA times (1 + N)
// - rail_a limit never drops below the floor code
// - irq flags, clear and mask sit at the three top addresses
// - idle shorter than the minimum raises the rail limit
`include "bcr_consts.vh"
module bcr_buck_ctrl #(
   parameter NREG = 28
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [31:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        bat_low_in,
   input  wire        hs_closed_in,
   input  wire        ls_closed_in,
   input  wire        rail_a_idle_in,
   input  wire        charge_done_in,
   output wire        bias_on,
   output wire        conv_active,
   output wire        conv_sleep,
   output wire        lv_settings,
   output wire [1:0]  charge_rail,
   output wire [4:0]  current_limit_level,
   output wire        rail_a_quick_ramp,
   output wire        sw_force_next,
   output wire        irq
);
   localparam S_OFF  = 2'b00;
   localparam S_WAIT = 2'b01;
   localparam S_RUN  = 2'b10;
   localparam NPIN   = 5;

   integer i;
   reg  [15:0] mem_q [0:NREG-1];
   reg  [NPIN-1:0] s1_q;
   reg  [NPIN-1:0] s2_q;
   reg  [NPIN-1:0] s3_q;
   reg  [NPIN-1:0] st_q;
   wire [NPIN-1:0] pin_in;
   reg  [1:0]  state_q;
   reg  [9:0]  wait_q;
   reg  [4:0]  lim_q;
   reg  [13:0] idle_ns_q;
   reg         idle_prev_q;
   reg  [12:0] sw_t_q;
   reg         to_done_q;
   reg         had_to_q;
   reg         chg_prev_q;
   reg  [3:0]  to_cnt_q;
   reg  [3:0]  ok_cnt_q;
   reg  [1:0]  slot_q;
   reg         flag_q;
   reg  [31:0] prdata_q;
   reg         active_q;
   reg         sleep_q;
   reg         force_q;
   reg  [1:0]  rail_q;
   reg  [4:0]  lim_out_q;

   function [15:0] rst_val;
      input integer k;
      begin
         case (k)
            0: rst_val = `BCR_RST_CTRL0;
            1: rst_val = `BCR_RST_CTRL1;
            2: rst_val = `BCR_RST_CTRL2;
            3: rst_val = `BCR_RST_RA0;
            4: rst_val = `BCR_RST_RA1;
            default: rst_val = 16'h0000;
         endcase
      end
   endfunction

   // three-stage pin synchroniser, a change counts once stages two and three agree
   assign pin_in = {charge_done_in, rail_a_idle_in, ls_closed_in, hs_closed_in, bat_low_in};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= {NPIN{1'b0}};
         s2_q <= {NPIN{1'b0}};
         s3_q <= {NPIN{1'b0}};
         st_q <= {NPIN{1'b0}};
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (st_q & (s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q));
      end
   end
   wire bat_low = st_q[0];
   wire sw_closed = st_q[1] | st_q[2];
   wire idle_now = st_q[3];
   wire chg_now = st_q[4];

   // apb decode on the low byte of the index
   wire [7:0] lo = paddr[9:2];
   wire [7:0] off = lo - `BCR_LO_FIRST;
   wire [4:0] slot = off[5:1];
   // the full index would never match an eight-bit slice, so compare low bytes only
   wire mapped = (paddr[1:0] == 2'b00) && (lo >= `BCR_LO_FIRST) &&
                 (lo <= `BCR_LO_LAST) && !lo[0];
   wire ro_slot = ((slot >= `BCR_SLOT_STAT0) && (slot <= `BCR_SLOT_STAT4)) ||
                  (slot == `BCR_SLOT_FLAGS) || (slot == `BCR_SLOT_CLEAR);
   wire acc = psel & penable;
   wire wr = acc & pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   wire [15:0] c0 = mem_q[`BCR_SLOT_CTRL0];
   wire [15:0] c1 = mem_q[`BCR_SLOT_CTRL1];
   wire [15:0] c2 = mem_q[`BCR_SLOT_CTRL2];
   wire [15:0] a0 = mem_q[`BCR_SLOT_RA0];
   wire [15:0] a1 = mem_q[`BCR_SLOT_RA1];
   wire [15:0] msk = mem_q[`BCR_SLOT_MASK];

   // register storage; live status slots are not stored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < NREG; i = i + 1)
            mem_q[i] <= rst_val(i);
      end else if (wr && !ro_slot) begin
         mem_q[slot] <= pwdata[15:0];
      end
   end

   // run mode decode and start-up wait
   wire [1:0] mode = c0[`BCR_F_MODE];
   wire mode_on = (mode == 2'b01) || (mode == 2'b10);
   wire [4:0] dly = c1[`BCR_F_DELAY];
   wire [31:0] dly_prod = dly * `BCR_CYC_PER_US;
   wire [9:0] dly_cyc = dly_prod[9:0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_OFF;
         wait_q <= 10'h000;
      end else begin
         case (state_q)
            S_OFF: begin
               if (mode_on) begin
                  wait_q <= dly_cyc;
                  state_q <= (dly == 5'h00) ? S_RUN : S_WAIT;
               end
            end
            S_WAIT: begin
               if (!mode_on) begin
                  state_q <= S_OFF;
               end else if (wait_q <= 10'h001) begin
                  state_q <= S_RUN;
               end else begin
                  wait_q <= wait_q - 10'h001;
               end
            end
            S_RUN: begin
               if (!mode_on)
                  state_q <= S_OFF;
            end
            default: state_q <= S_OFF;
         endcase
      end
   end
   assign bias_on = (state_q != S_OFF);

   // rail_a current limit regulation
   wire lv_sel = c0[`BCR_F_LVSW] & bat_low;
   wire [4:0] ceil = lv_sel ? {1'b0, a1[`BCR_F_CEIL_LV]} : a0[`BCR_F_CEIL_HV];
   wire [4:0] floor_c = a0[`BCR_F_FLOOR];
   wire [4:0] step = a0[`BCR_F_QRAMP] ? 5'h02 : 5'h01;
   wire [31:0] min_full = a1[`BCR_F_IDLE_MIN] * `BCR_IDLE_STEP_NS;
   wire [13:0] min_ns = min_full[13:0];
   wire [5:0] max_code = {1'b0, a1[`BCR_F_IDLE_MIN]} + {1'b0, a1[`BCR_F_HYST]};
   wire [31:0] max_full = max_code * `BCR_IDLE_STEP_NS;
   wire [13:0] max_ns = max_full[13:0];
   wire [31:0] glob_full = c1[`BCR_F_GIDLE] * `BCR_IDLE_STEP_NS;
   wire [13:0] glob_ns = glob_full[13:0];
   // idle time saturates so a long quiet rail cannot wrap back under the limits
   wire [31:0] idle_sum = idle_ns_q + `BCR_CLK_NS;
   wire [13:0] idle_nx = (idle_sum > 32'h00003FFF) ? 14'h3FFF : idle_sum[13:0];
   wire cross_max = idle_now && (idle_ns_q < max_ns) && (idle_nx >= max_ns);
   wire cross_glob = idle_now && (idle_ns_q < glob_ns) && (idle_nx >= glob_ns);
   wire short_idle = idle_prev_q && !idle_now && (idle_ns_q < min_ns);
   reg [6:0] lim_w;
   always @* begin
      lim_w = {2'b00, lim_q};
      if (short_idle)
         lim_w = lim_w + {2'b00, step};
      if (cross_max)
         lim_w = (lim_w > {2'b00, step}) ? lim_w - {2'b00, step} : 7'h00;
      if (cross_glob)
         lim_w = (lim_w > {1'b0, step, 1'b0}) ? lim_w - {1'b0, step, 1'b0} : 7'h00;
      if (lim_w > {2'b00, ceil})
         lim_w = {2'b00, ceil};
      if (lim_w < {2'b00, floor_c})
         lim_w = {2'b00, floor_c};
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lim_q <= `BCR_RST_LIM;
         idle_ns_q <= 14'h0000;
         idle_prev_q <= 1'b0;
      end else begin
         lim_q <= lim_w[4:0];
         idle_prev_q <= idle_now;
         idle_ns_q <= idle_now ? idle_nx : 14'h0000;
      end
   end

   // switch on-time watchdog in half-nanosecond units
   wire [31:0] to_full = c1[`BCR_F_TOLIM] * `BCR_TO_STEP_HNS;
   wire [12:0] to_lim = to_full[12:0];
   wire [31:0] sw_sum = sw_t_q + `BCR_CLK_HNS;
   wire to_evt = sw_closed && (sw_t_q > to_lim) && !to_done_q;
   wire chg_evt = chg_now && !chg_prev_q;
   wire [3:0] to_inc = (to_cnt_q == 4'hF) ? 4'hF : to_cnt_q + 4'h1;
   wire [3:0] ok_inc = ok_cnt_q + 4'h1;
   wire irq_set = to_evt && (to_inc == c2[`BCR_F_TRIG]);
   wire clr_wr = wr && (slot == `BCR_SLOT_CLEAR) && pwdata[0];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_t_q <= 13'h0000;
         to_done_q <= 1'b0;
         had_to_q <= 1'b0;
         chg_prev_q <= 1'b0;
         to_cnt_q <= 4'h0;
         ok_cnt_q <= 4'h0;
         slot_q <= 2'b00;
         flag_q <= 1'b0;
      end else begin
         chg_prev_q <= chg_now;
         if (!sw_closed) begin
            sw_t_q <= 13'h0000;
            to_done_q <= 1'b0;
         end else begin
            if (sw_t_q < 13'h1FFF - `BCR_CLK_HNS)
               sw_t_q <= sw_sum[12:0];
            if (to_evt)
               to_done_q <= 1'b1;
         end
         if (to_evt) begin
            to_cnt_q <= to_inc;
            ok_cnt_q <= 4'h0;
            had_to_q <= 1'b1;
         end else if (chg_evt) begin
            had_to_q <= 1'b0;
            if (had_to_q) begin
               ok_cnt_q <= 4'h0;
            end else if (ok_inc >= c2[`BCR_F_RES]) begin
               to_cnt_q <= 4'h0;
               ok_cnt_q <= 4'h0;
            end else begin
               ok_cnt_q <= ok_inc;
            end
         end
         if (chg_evt)
            slot_q <= slot_q + 2'b01;
         // a new event in the clearing cycle keeps the flag set
         if (irq_set)
            flag_q <= 1'b1;
         else if (clr_wr)
            flag_q <= 1'b0;
      end
   end

   // outputs to the power stage; all registered except bias_on, lv_settings and irq, which are gated from registers
   wire [7:0] prio = c0[`BCR_F_PRIO];
   wire [1:0] next_rail = prio[{slot_q, 1'b0} +: 2];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= 1'b0;
         sleep_q <= 1'b0;
         force_q <= 1'b0;
         rail_q <= 2'b00;
         lim_out_q <= `BCR_RST_LIM;
      end else begin
         active_q <= (state_q == S_RUN) && (mode == 2'b01);
         sleep_q <= (state_q == S_RUN) && (mode == 2'b10);
         force_q <= to_evt;
         rail_q <= next_rail;
         // fast launch holds the limit at full scale until the converter runs
         lim_out_q <= (c0[`BCR_F_FAST] && state_q == S_WAIT) ? 5'h1F : lim_q;
      end
   end
   assign conv_active = active_q;
   assign conv_sleep = sleep_q;
   assign sw_force_next = force_q;
   assign charge_rail = rail_q;
   assign current_limit_level = lim_out_q;
   assign lv_settings = lv_sel;
   assign rail_a_quick_ramp = a0[`BCR_F_QRAMP];
   assign irq = flag_q & msk[0];

   // read data is captured in the setup cycle so it stands through the access
   reg [15:0] rd_w;
   always @* begin
      rd_w = 16'h0000;
      if (mapped) begin
         case (slot)
            5'h10: rd_w = {12'h000, lv_sel, bias_on, state_q};
            5'h11: rd_w = {11'h000, lim_q};
            5'h12: rd_w = {8'h00, ok_cnt_q, to_cnt_q};
            5'h13: rd_w = {12'h000, slot_q, rail_q};
            5'h14: rd_w = {11'h000, st_q};
            `BCR_SLOT_FLAGS: rd_w = {15'h0000, flag_q};
            `BCR_SLOT_CLEAR: rd_w = 16'h0000;
            default: rd_w = mem_q[slot];
         endcase
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else if (psel && !penable)
         prdata_q <= {16'h0000, rd_w};
   end
   assign prdata = prdata_q;
endmodule // bcr_buck_ctrl

// *** bcr_buck_ctrl_monitor.sv ***
module bcr_buck_ctrl_monitor #(
   parameter NREG = 28
) (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        bias_on,
   input wire        conv_active,
   input wire        conv_sleep,
   input wire        rail_a_quick_ramp,
   input wire        sw_force_next,
   input wire        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr(a);
      psel && penable && pwrite && paddr[9:2] == a;
   endsequence
   sequence s_rd(a);
      psel && penable && !pwrite && paddr[9:2] == a;
   endsequence
   AST_READY: assert property (pready)
      else $error("pready low");
   AST_ERR_ONLY_ACCESS: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access phase");
   AST_ODD_INDEX_ERR: assert property (psel && penable && paddr[2] |-> pslverr)
      else $error("odd index not refused");
   AST_PRDATA_HIGH_ZERO: assert property (psel && penable |-> prdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   AST_CLEAR_READS_ZERO: assert property (s_rd(8'hB6) |-> prdata == 32'h0)
      else $error("irq clear register read not zero");
   AST_QRAMP_FOLLOWS: assert property (s_wr(8'h88) |=> rail_a_quick_ramp == $past(pwdata[15]))
      else $error("quick ramp output not written value");
   AST_MASK_GATES: assert property (s_wr(8'hB8) ##0 !pwdata[0] |=> !irq)
      else $error("irq high with mask cleared");
   AST_FORCE_ONE_CYCLE: assert property (sw_force_next |=> !sw_force_next)
      else $error("force pulse longer than one cycle");
   AST_MODE_EXCLUSIVE: assert property (!(conv_active && conv_sleep))
      else $error("active and sleep together");
   AST_START_BIAS: assert property (s_wr(8'h82) ##0 pwdata[1:0] == 2'b01 |-> ##[1:3] bias_on)
      else $error("bias not on after start");
   AST_BIAS_BEFORE_RUN: assert property ($rose(conv_active) |-> $past(bias_on))
      else $error("converter active without bias");
endmodule // bcr_buck_ctrl_monitor
bind bcr_buck_ctrl bcr_buck_ctrl_monitor #(.NREG(NREG)) u_mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bias_on, .conv_active,
   .conv_sleep, .rail_a_quick_ramp, .sw_force_next, .irq);

// *** bcr_stage_model.sv ***
module bcr_stage_model (
   input  wire  pclk,
   output logic bat_low_in,
   output logic hs_closed_in,
   output logic ls_closed_in,
   output logic rail_a_idle_in,
   output logic charge_done_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {bat_low_in, hs_closed_in, ls_closed_in, rail_a_idle_in, charge_done_in} = 5'h00;
   end
   // one charge event: high switch held, short low switch, then the done edge;
   // levels stay long enough to pass the pin synchronisers
   task charge(input int hold);
      @(posedge pclk);
      for (int k = 0; k < hold + 14; k++) begin
         hs_closed_in   <= (k < hold);
         ls_closed_in   <= (k >= hold) && (k < hold + 2);
         charge_done_in <= (k >= hold + 2) && (k < hold + 8);
         rail_a_idle_in <= (k >= hold + 2);
         @(posedge pclk);
      end
   endtask
   task set_bat(input logic v);
      @(posedge pclk);
      bat_low_in <= v;
   endtask
endmodule // bcr_stage_model

// *** bcr_buck_ctrl_tb_top.sv ***
module bcr_buck_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, er;
   logic [31:0] paddr, pwdata, rd, prdata;
   wire         pready, pslverr, bat, hs, ls, idle, chg, bias_on, conv_active, conv_sleep;
   wire         lv_settings, rail_a_quick_ramp, sw_force_next, irq;
   wire  [1:0]  charge_rail;
   wire  [4:0]  lim;
   int          errors, check_count, cyc, pulse_cnt;
   logic [1:0]  modes [4] = '{2'd0, 2'd1, 2'd3, 2'd2};
   bcr_buck_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bat_low_in(bat), .hs_closed_in(hs), .ls_closed_in(ls),
      .rail_a_idle_in(idle), .charge_done_in(chg), .bias_on(bias_on),
      .conv_active(conv_active), .conv_sleep(conv_sleep), .lv_settings(lv_settings),
      .charge_rail(charge_rail), .current_limit_level(lim),
      .rail_a_quick_ramp(rail_a_quick_ramp), .sw_force_next(sw_force_next), .irq(irq));
   bcr_stage_model stage (.pclk(pclk), .bat_low_in(bat), .hs_closed_in(hs),
      .ls_closed_in(ls), .rail_a_idle_in(idle), .charge_done_in(chg));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task end_of_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard: the whole sequence needs well under 3000 cycles
   always @(posedge pclk) begin
      cyc++;
      if (sw_force_next === 1'b1) pulse_cnt++;
      if (cyc == 8000) begin
         errors++;
         end_of_test();
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {22'h0, a, 2'b00};
      pwdata  <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d);
      // the write lands in the edge's update phase; look at outputs once settled
      @(negedge pclk);
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [15:0] e);
      apb(1'b0, a, 16'h0);
      chk(n, {16'h0, e}, rd);
   endtask
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr  = 32'h0;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctrl0", 8'h82, 16'h2F24);
      rdc("ctrl1", 8'h84, 16'h5410);
      rdc("ctrl2", 8'h86, 16'h882D);
      rdc("rail_a0", 8'h88, 16'hA1A4);
      rdc("rail_a1", 8'h8A, 16'hD890);
      rdc("unmapped", 8'h83, 16'h0);
      chk("unmapped_err", 1, er);
      chk("qramp_rst", 1, rail_a_quick_ramp);
      wr(8'h88, 16'h21A4);
      chk("qramp_off", 0, rail_a_quick_ramp);
      rdc("rail_a0_wr", 8'h88, 16'h21A4);
      stage.set_bat(1'b1);
      repeat (6) @(posedge pclk);
      chk("lv_on", 1, lv_settings);
      wr(8'h82, 16'h0F24);
      chk("lv_off", 0, lv_settings);
      wr(8'h82, 16'h2F24);
      stage.set_bat(1'b0);
      // delay 1 us is 25 cycles at this clock; switch limit 2 units is 4 cycles
      wr(8'h84, 16'h0C02);
      wr(8'h82, 16'h6F25);
      repeat (8) @(posedge pclk);
      chk("bias_wait", 1, bias_on);
      chk("active_wait", 0, conv_active);
      chk("fast_limit", 5'h1F, lim);
      repeat (30) @(posedge pclk);
      chk("active_run", 1, conv_active);
      wr(8'h84, 16'h0402);
      rdc("ctrl1_wr", 8'h84, 16'h0402);
      foreach (modes[i]) begin
         wr(8'h82, 16'h2F24 | modes[i]);
         repeat (4) @(posedge pclk);
         chk("mode_active", modes[i] == 2'd1, conv_active);
         chk("mode_sleep", modes[i] == 2'd2, conv_sleep);
      end
      wr(8'h86, 16'h222D);
      stage.charge(20);
      stage.charge(20);
      chk("force_pulses", 2, pulse_cnt);
      chk("irq_masked", 0, irq);
      rdc("flag_set", 8'hB4, 16'h1);
      wr(8'hB8, 16'h1);
      chk("irq_on", 1, irq);
      wr(8'hB4, 16'h0);
      rdc("flag_ro", 8'hB4, 16'h1);
      wr(8'hB6, 16'h1);
      chk("irq_clr", 0, irq);
      rdc("clear_rd", 8'hB6, 16'h0);
      stage.charge(2);
      stage.charge(2);
      rdc("cnt_zero", 8'hA6, 16'h0);
      stage.charge(20);
      chk("cnt_cleared", 0, irq);
      stage.charge(20);
      chk("cnt_retrig", 1, irq);
      wr(8'hB8, 16'h0);
      // reversed order 0x1B; six charge events so far, the next one takes the top pair
      wr(8'h82, 16'h28DD);
      stage.charge(2);
      chk("rail_id", 2'b00, charge_rail);
      stage.charge(2);
      chk("rail_wrap", 2'b11, charge_rail);
      // floor and ceiling both 0x0C pin the limit whatever the idle history
      wr(8'h88, 16'h218C);
      repeat (3) @(posedge pclk);
      chk("lim_clamp", 5'h0C, lim);
      end_of_test();
   end
endmodule // bcr_buck_ctrl_tb_top
